// >>> design/fcl_defines.svh
// Offsets, field codes, reset values and timing counts of the configuration loader
`ifndef FCL_DEFINES_SVH
`define FCL_DEFINES_SVH
`define FCL_OFF_BOD 8'h01
`define FCL_OFF_OSC 8'h02
`define FCL_OFF_TCD 8'h04
`define FCL_OFF_SYS0 8'h05
`define FCL_OFF_SYS1 8'h06
`define FCL_OFF_APPLICATION_END_FUSE 8'h07
`define FCL_OFF_BOOT_SECTION_END 8'h08
`define FCL_OFF_LOCK 8'h0a
`define FCL_OFF_STATUS 8'h10
`define FCL_OFF_OSCCAL 8'h11
`define FCL_OFF_LAYOUT 8'h12
`define FCL_NUM_BYTES 4'd11
`define FCL_SYS0_RESET 8'hc4
`define FCL_LOCK_OPEN 8'hc5
`define FCL_FREQ_16M 2'h1
`define FCL_FREQ_20M 2'h2
`define FCL_PIN_GPIO 2'h0
`define FCL_CLK_HZ 100000000
`define FCL_SLOW_HZ 32768
`define FCL_SLOW_DIV (`FCL_CLK_HZ / `FCL_SLOW_HZ)
`define FCL_PIN_HOLD_SLOW 768
`define FCL_MS_CYCLES (`FCL_CLK_HZ / 1000)
`define FCL_BLOCK_BYTES 256
`endif

// >>> design/fcl_loader.sv
// Configuration loader: copies fuse bytes to peripheral settings during reset
//
// Overview of operation
// - Brown-out settings reload only on power-on
// - Bits 7:5 become brown-out threshold
// - Bit 4 becomes brown-out sample rate
// - Bits 3:2 become active/idle mode
// - Bits 1:0 become sleep mode
// - Oscillator fuse bit 7 locks oscillator calibration
// - Frequency code picks 16/20 MHz calibration
// - Timer-D byte copied into fault control
// - Timer-D compare settings reload only on power-on
// - Bits 7:4 enable compare pin outputs
// - Bits 3:0 give compare default levels
// - Bits 7:6 select CRC scan range
// - Bits 3:2 select reset pin function
// - GPIO reset pin driver off 768 slow cycles
// - Save bit keeps EEPROM unless locked
// - Start-up code selects 0 to 64 ms
// - Application end counts 256-byte blocks
// - Zero application end: code to top
// - Both ends zero: all flash boot
`timescale 1ns/100ps
`include "fcl_defines.svh"
module fcl_loader
  import fcl_pkg::*;
#(
  parameter int FLASH_BLOCKS = 32,
  parameter int MS_CYCLES = `FCL_MS_CYCLES,
  parameter int SLOW_DIV = `FCL_SLOW_DIV,
  parameter logic [7:0] CAL16_FACTORY = 8'h40,
  parameter logic [3:0] TEMP16_FACTORY = 4'h8,
  parameter logic [7:0] CAL20_FACTORY = 8'h50,
  parameter logic [3:0] TEMP20_FACTORY = 4'h8
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Reset cause and system reset request
  input wire logic i_por,
  input wire logic i_sys_reset,
  // Fuse storage read port, data one cycle after address
  output logic [3:0] o_fuse_addr,
  output logic o_fuse_rd,
  input wire logic [7:0] i_fuse_data,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Chip erase request
  input wire logic i_chip_erase,
  output logic o_erase_eeprom,
  // Peripheral settings
  output fcl_bod_t o_bod,
  output fcl_osc_t o_osc,
  output logic [7:0] o_timer_d_fault_control,
  output logic [1:0] o_crc_scan_source,
  output logic [1:0] o_reset_pin_function,
  output logic o_pin_driver_en,
  output logic o_keep_eeprom_on_erase,
  output logic [7:0] o_application_section_end,
  output logic [7:0] o_boot_section_end,
  output logic o_all_boot,
  output logic [15:0] o_app_code_end_addr,
  output logic o_running
);

  fcl_state_t state_r;
  logic [3:0] idx_r;
  logic [3:0] idx_d_r;
  logic [7:0] fuse_r [0:10];
  logic por_seen_r;
  logic [31:0] delay_r;
  logic [15:0] div_r;
  logic [9:0] pin_cnt_r;
  logic hold_r;
  logic [7:0] sys0;
  logic locked;

  assign sys0 = fuse_r[5];
  assign locked = (fuse_r[10] != `FCL_LOCK_OPEN);

  // Power-on cause is latched in the idle cycle after reset so the loader knows what to refresh
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      por_seen_r <= 1'b0;
    else if (state_r == FCL_IDLE)
      por_seen_r <= i_por;
  end

  // Sequencer: read every fuse byte, wait start-up, then run
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_r <= FCL_IDLE;
      idx_r <= 4'h0;
      delay_r <= 32'h0;
    end
    else
    begin
      case (state_r)
        FCL_IDLE:
        begin
          idx_r <= 4'h0;
          state_r <= FCL_READ;
        end
        FCL_READ:
        begin
          if (idx_r == `FCL_NUM_BYTES)
          begin
            // Start-up delay: 0, then 1 ms doubling per code
            if (fuse_r[6][2:0] == 3'h0)
              delay_r <= 32'h0;
            else
              delay_r <= 32'(MS_CYCLES) << (fuse_r[6][2:0] - 3'h1);
            state_r <= FCL_WAIT;
          end
          else
            idx_r <= idx_r + 4'h1;
        end
        FCL_WAIT:
        begin
          if (delay_r == 32'h0)
            state_r <= FCL_RUN;
          else
            delay_r <= delay_r - 32'h1;
        end
        FCL_RUN:
          state_r <= FCL_RUN;
        default:
          state_r <= FCL_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_fuse_addr <= 4'h0;
      o_fuse_rd <= 1'b0;
    end
    else
    begin
      o_fuse_rd <= (state_r == FCL_READ) && (idx_r != `FCL_NUM_BYTES);
      o_fuse_addr <= idx_r;
    end
  end

  // Storage answers one cycle after it takes the request, so the byte is captured one edge later
  logic fuse_rd_d_r;
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      fuse_rd_d_r <= 1'b0;
      idx_d_r <= 4'h0;
    end
    else
    begin
      fuse_rd_d_r <= o_fuse_rd;
      idx_d_r <= o_fuse_addr;
    end
  end

  // Fuse shadow array; written only by the loader, never by software
  genvar g;
  generate
    for (g = 0; g < 11; g++)
    begin : g_shadow
      always_ff @(posedge i_clk)
      begin
        if (!i_rst_n)
          fuse_r[g] <= (g == 5) ? `FCL_SYS0_RESET : 8'h00;
        else if (fuse_rd_d_r && idx_d_r == 4'(g))
          fuse_r[g] <= i_fuse_data;
      end
    end
  endgenerate

  logic load_done;
  assign load_done = (state_r == FCL_WAIT) && (delay_r == 32'h0);

  // Per compare channel: pin enable in the upper nibble, default level in the lower
  wire logic [7:0] tcd_nxt;
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++)
    begin : g_compare
      assign tcd_nxt[ch + 4] = fuse_r[4][ch + 4];
      assign tcd_nxt[ch] = fuse_r[4][ch];
    end
  endgenerate

  // Brown-out and timer-D compare settings survive non-power-on resets
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      // Only a power-on reset clears them; a warm reset keeps what was loaded
      if (i_por)
      begin
        o_bod <= '0;
        o_timer_d_fault_control <= 8'h00;
      end
    end
    else if (load_done && por_seen_r)
    begin
      o_bod.threshold <= fuse_r[1][7:5];
      o_bod.sample_rate <= fuse_r[1][4];
      o_bod.active_mode <= fuse_r[1][3:2];
      o_bod.sleep_mode <= fuse_r[1][1:0];
      o_timer_d_fault_control <= tcd_nxt;
    end
  end

  // Oscillator selection and calibration
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_osc <= '0;
    else if (load_done)
    begin
      o_osc.calibration_lock <= fuse_r[2][7];
      o_osc.osc_frequency_select <= fuse_r[2][1:0];
      case (fuse_r[2][1:0])
        `FCL_FREQ_16M:
        begin
          o_osc.fast_osc_calibration <= CAL16_FACTORY;
          o_osc.fast_osc_temp_calibration <= TEMP16_FACTORY;
        end
        `FCL_FREQ_20M:
        begin
          o_osc.fast_osc_calibration <= CAL20_FACTORY;
          o_osc.fast_osc_temp_calibration <= TEMP20_FACTORY;
        end
        default:
        begin
          // Reserved codes leave the calibration at its previous value
          o_osc.fast_osc_calibration <= o_osc.fast_osc_calibration;
          o_osc.fast_osc_temp_calibration <= o_osc.fast_osc_temp_calibration;
        end
      endcase
    end
    else if (i_wr && i_addr == `FCL_OFF_OSCCAL && !o_osc.calibration_lock)
      o_osc.fast_osc_calibration <= i_wdata;
  end

  // System configuration and flash partitioning
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_crc_scan_source <= 2'h3;
      o_reset_pin_function <= 2'h1;
      o_keep_eeprom_on_erase <= 1'b0;
      o_application_section_end <= 8'h00;
      o_boot_section_end <= 8'h00;
      o_all_boot <= 1'b1;
      o_app_code_end_addr <= 16'h0;
      o_running <= 1'b0;
    end
    else
    begin
      o_running <= (state_r == FCL_RUN);
      if (load_done)
      begin
        o_crc_scan_source <= sys0[7:6];
        o_reset_pin_function <= sys0[3:2];
        o_keep_eeprom_on_erase <= sys0[0];
        o_application_section_end <= fuse_r[7];
        o_boot_section_end <= fuse_r[8];
        o_all_boot <= (fuse_r[7] == 8'h00) && (fuse_r[8] == 8'h00);
        if (fuse_r[7] == 8'h00)
          o_app_code_end_addr <= 16'(FLASH_BLOCKS * `FCL_BLOCK_BYTES);
        else
          o_app_code_end_addr <= {fuse_r[7], 8'h00};
      end
    end
  end

  // Chip erase: a locked part always loses its EEPROM
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_erase_eeprom <= 1'b0;
    else
      o_erase_eeprom <= i_chip_erase && (locked || !o_keep_eeprom_on_erase);
  end

  // Slow-oscillator tick divider and pin hold-off counter.
  // Holding the driver off avoids fighting a high-voltage programming entry.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || i_sys_reset)
    begin
      div_r <= 16'h0;
      pin_cnt_r <= 10'h0;
      hold_r <= 1'b1;
    end
    else if (hold_r)
    begin
      if (div_r == 16'(SLOW_DIV - 1))
      begin
        div_r <= 16'h0;
        if (pin_cnt_r == 10'(`FCL_PIN_HOLD_SLOW - 1))
          hold_r <= 1'b0;
        pin_cnt_r <= pin_cnt_r + 10'h1;
      end
      else
        div_r <= div_r + 16'h1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_pin_driver_en <= 1'b0;
    else
      // A system reset drops the driver at once, on the same edge that restarts the hold-off counter
      o_pin_driver_en <= !hold_r && !i_sys_reset && (state_r == FCL_RUN)
        && (o_reset_pin_function == `FCL_PIN_GPIO);
  end

  // Read-only register view; writes other than calibration are ignored
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_rdata <= 8'h00;
    else if (i_rd)
    begin
      case (i_addr)
        `FCL_OFF_BOD: o_rdata <= fuse_r[1];
        `FCL_OFF_OSC: o_rdata <= fuse_r[2];
        `FCL_OFF_TCD: o_rdata <= fuse_r[4];
        `FCL_OFF_SYS0: o_rdata <= fuse_r[5];
        `FCL_OFF_SYS1: o_rdata <= fuse_r[6];
        `FCL_OFF_APPLICATION_END_FUSE: o_rdata <= fuse_r[7];
        `FCL_OFF_BOOT_SECTION_END: o_rdata <= fuse_r[8];
        `FCL_OFF_LOCK: o_rdata <= fuse_r[10];
        `FCL_OFF_STATUS: o_rdata <= {4'h0, hold_r, locked, por_seen_r, o_running};
        `FCL_OFF_OSCCAL: o_rdata <= o_osc.fast_osc_calibration;
        default: o_rdata <= 8'h00;
      endcase
    end
    else
      o_rdata <= 8'h00;
  end
endmodule : fcl_loader

// >>> design/fcl_pkg.sv
// Types shared by the configuration loader
package fcl_pkg;
  typedef enum logic [3:0] {
    FCL_IDLE = 4'b0001,
    FCL_READ = 4'b0010,
    FCL_WAIT = 4'b0100,
    FCL_RUN = 4'b1000
  } fcl_state_t;

  typedef struct packed {
    logic [2:0] threshold;
    logic sample_rate;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
  } fcl_bod_t;

  typedef struct packed {
    logic [3:0] compare_pin_enable;
    logic [3:0] compare_default_level;
  } fcl_tcd_t;

  typedef struct packed {
    logic calibration_lock;
    logic [1:0] osc_frequency_select;
    logic [7:0] fast_osc_calibration;
    logic [3:0] fast_osc_temp_calibration;
  } fcl_osc_t;
endpackage : fcl_pkg

// >>> tb/fcl_fuse_model.sv
// Fuse storage model: one byte per read, data in the following cycle
`timescale 1ns/100ps
module fcl_fuse_model (
  // Clock
  input wire logic i_clk,
  // Read port
  input wire logic [3:0] i_addr,
  input wire logic i_rd,
  output logic [7:0] o_data
);
  logic [7:0] mem [11];
  logic [3:0] addr_r;
  logic rd_r;
  logic [7:0] junk_r = 8'h5a;
  always @(posedge i_clk)
  begin
    rd_r <= i_rd;
    addr_r <= i_addr;
    junk_r <= ~junk_r;
  end
  // Outside the data cycle the bus toggles, so a late sample never looks like a stale byte
  assign o_data = rd_r ? mem[addr_r] : junk_r;
endmodule : fcl_fuse_model

// >>> tb/fcl_loader_checker.sv
// Port assertions of the configuration loader
`timescale 1ns/100ps
module fcl_loader_checker
  import fcl_pkg::*;
(
  // Watched ports
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sys_reset,
  input wire logic i_chip_erase,
  input wire logic o_fuse_rd,
  input wire logic o_erase_eeprom,
  input wire fcl_bod_t o_bod,
  input wire logic [1:0] o_reset_pin_function,
  input wire logic o_pin_driver_en,
  input wire logic o_keep_eeprom_on_erase,
  input wire logic [7:0] o_application_section_end,
  input wire logic [7:0] o_boot_section_end,
  input wire logic o_all_boot,
  input wire logic [15:0] o_app_code_end_addr,
  input wire logic o_running
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_erase_cause: assert property (i_chip_erase && !o_keep_eeprom_on_erase |=> o_erase_eeprom)
    else $error("erase missing");
  a_erase_source: assert property (o_erase_eeprom |-> $past(i_chip_erase))
    else $error("erase without request");
  a_pin_hold: assert property (o_pin_driver_en |-> o_running && o_reset_pin_function == 2'h0)
    else $error("pin driver early");
  a_pin_restart: assert property (i_sys_reset |=> !o_pin_driver_en [*2])
    else $error("pin driver after reset");
  a_load_done: assert property (o_running |-> !o_fuse_rd)
    else $error("fuse read while running");
  a_bod_kept: assert property (o_running && $past(o_running) |-> $stable(o_bod))
    else $error("brown-out changed");
  a_all_boot: assert property (o_running |->
    o_all_boot == (o_application_section_end == 8'h00 && o_boot_section_end == 8'h00))
    else $error("all boot wrong");
  a_app_end: assert property (o_running && o_application_section_end != 8'h00 |->
    o_app_code_end_addr == {o_application_section_end, 8'h00})
    else $error("code end wrong");
endmodule : fcl_loader_checker
bind fcl_loader fcl_loader_checker u_chk (.i_clk, .i_rst_n, .i_sys_reset, .i_chip_erase, .o_fuse_rd,
  .o_erase_eeprom, .o_bod, .o_reset_pin_function, .o_pin_driver_en, .o_keep_eeprom_on_erase,
  .o_application_section_end, .o_boot_section_end, .o_all_boot, .o_app_code_end_addr, .o_running);

// >>> tb/tb_fcl_loader.sv
// Self-checking testbench of the configuration loader
`timescale 1ns/100ps
module tb_fcl_loader;
  import fcl_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_por = 1'b1;
  logic i_sys_reset = 1'b0;
  logic i_chip_erase = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [3:0] o_fuse_addr;
  logic [7:0] i_fuse_data, o_rdata, o_timer_d_fault_control, o_application_section_end, o_boot_section_end;
  logic [1:0] o_crc_scan_source, o_reset_pin_function;
  logic o_fuse_rd, o_erase_eeprom, o_pin_driver_en, o_keep_eeprom_on_erase, o_all_boot, o_running;
  logic [15:0] o_app_code_end_addr;
  fcl_bod_t o_bod;
  fcl_osc_t o_osc;
  int n_fail = 0;
  int n_compared = 0;
  always #5 i_clk = ~i_clk;
  // Short ms and slow-clock counts keep the run brief
  fcl_loader #(.MS_CYCLES(4), .SLOW_DIV(2), .CAL16_FACTORY(8'h3c), .CAL20_FACTORY(8'h5d),
    .TEMP20_FACTORY(4'h3)) DUT (.i_clk, .i_rst_n, .i_por, .i_sys_reset, .o_fuse_addr, .o_fuse_rd,
    .i_fuse_data, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_chip_erase, .o_erase_eeprom, .o_bod,
    .o_osc, .o_timer_d_fault_control, .o_crc_scan_source, .o_reset_pin_function, .o_pin_driver_en,
    .o_keep_eeprom_on_erase, .o_application_section_end, .o_boot_section_end, .o_all_boot,
    .o_app_code_end_addr, .o_running);
  fcl_fuse_model fuse (.i_clk, .i_addr(o_fuse_addr), .i_rd(o_fuse_rd), .o_data(i_fuse_data));
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic boot(input logic por, input int dly);
    int cyc;
    cyc = 0;
    i_por <= por;
    i_rst_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    while (cyc < 400 && o_running !== 1'b1)
    begin
      @(posedge i_clk);
      cyc++;
    end
    i_por <= 1'b0;
    chk("delay", 16'(cyc >= dly && cyc <= dly + 24), 16'h1);
  endtask : boot
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    // Read data stand until the next edge, so they are taken there
    @(posedge i_clk);
    chk("rdata", o_rdata, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic erase(input logic exp);
    @(posedge i_clk);
    i_chip_erase <= 1'b1;
    @(posedge i_clk);
    i_chip_erase <= 1'b0;
    #1 chk("erase", o_erase_eeprom, exp);
  endtask : erase
  task automatic print_verdict;
    $display("Compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    print_verdict();
  end
  initial
  begin
    fuse.mem = '{8'h00, 8'hf6, 8'h01, 8'h00, 8'h5a, 8'h81, 8'h03, 8'h10, 8'h04, 8'h00, 8'hc5};
    boot(1'b1, 16);
    chk("bod", o_bod, 8'hf6);
    chk("tcd", o_timer_d_fault_control, 8'h5a);
    chk("osc", o_osc, {1'b0, 2'h1, 8'h3c, 4'h8});
    chk("crc", o_crc_scan_source, 2'h2);
    chk("pinfn", o_reset_pin_function, 2'h0);
    chk("keep", o_keep_eeprom_on_erase, 1'b1);
    chk("codeend", o_app_code_end_addr, 16'h1000);
    chk("allboot", o_all_boot, 1'b0);
    chk("application_end_fuse", o_application_section_end, 8'h10);
    chk("boot_section_end", o_boot_section_end, 8'h04);
    rd(8'h01, 8'hf6);
    wr(8'h05, 8'h00);
    rd(8'h05, 8'h81);
    rd(8'h30, 8'h00);
    rd(8'h10, 8'h0b);
    erase(1'b0);
    chk("pin", o_pin_driver_en, 1'b0);
    repeat (1560) @(posedge i_clk);
    #1 chk("pin", o_pin_driver_en, 1'b1);
    rd(8'h10, 8'h03);
    @(posedge i_clk);
    i_sys_reset <= 1'b1;
    @(posedge i_clk);
    i_sys_reset <= 1'b0;
    repeat (1400) @(posedge i_clk);
    #1 chk("pin", o_pin_driver_en, 1'b0);
    repeat (200) @(posedge i_clk);
    #1 chk("pin", o_pin_driver_en, 1'b1);
    $display("Power-on load done");
    fuse.mem = '{8'h00, 8'h00, 8'h82, 8'h00, 8'h00, 8'hc9, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    boot(1'b0, 0);
    chk("bod", o_bod, 8'hf6);
    chk("tcd", o_timer_d_fault_control, 8'h5a);
    chk("osc", o_osc, {1'b1, 2'h2, 8'h5d, 4'h3});
    chk("crc", o_crc_scan_source, 2'h3);
    chk("pinfn", o_reset_pin_function, 2'h2);
    chk("allboot", o_all_boot, 1'b1);
    wr(8'h11, 8'h77);
    #1 chk("cal", o_osc.fast_osc_calibration, 8'h5d);
    erase(1'b1);
    $display("Warm reset load done");
    fuse.mem = '{8'h00, 8'h20, 8'h01, 8'h00, 8'h0f, 8'h44, 8'h07, 8'h00, 8'h04, 8'h00, 8'hc5};
    boot(1'b1, 256);
    chk("bod", o_bod, 8'h20);
    chk("tcd", o_timer_d_fault_control, 8'h0f);
    chk("crc", o_crc_scan_source, 2'h1);
    chk("pinfn", o_reset_pin_function, 2'h1);
    chk("codeend", o_app_code_end_addr, 16'h2000);
    chk("allboot", o_all_boot, 1'b0);
    wr(8'h11, 8'h77);
    #1 chk("cal", o_osc.fast_osc_calibration, 8'h77);
    erase(1'b1);
    $display("Long start-up load done");
    print_verdict();
  end
endmodule : tb_fcl_loader
